// File: hw/pcs_consts.vh
/*
 * constants of the pattern and clock status block: register indices,
 * field positions, reset values, pattern codes and timing figures.
 * assumes it is included by bare name inside the pcs design files.
 */
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// register indices, byte address is four times the index
`define PCS_IDX_DEV_MODE 8'hE7
`define PCS_IDX_CLK_STAT 8'hFE
`define PCS_IDX_PAT_STAT 8'hE1
`define PCS_IDX_CTRL 8'hE2
`define PCS_IDX_IRQ_STAT 8'hE3
`define PCS_IDX_IRQ_MASK 8'hE4
`define PCS_IDX_BEC_LO 8'hE5
`define PCS_IDX_BEC_HI 8'hE6

// status bit positions
`define PCS_BIT_COMPAT 0
`define PCS_BIT_REF_LOST 4
`define PCS_BIT_MST_LOST 3

// control register fields
`define PCS_CTRL_LEGACY_DIS 0
`define PCS_CTRL_IRQ_EN 1
`define PCS_CTRL_ALARM_SIM 2
`define PCS_CTRL_POLY_LO 3
`define PCS_CTRL_POLY_HI 4
`define PCS_CTRL_W 5
`define PCS_CTRL_RST 5'h00

// interrupt status and mask fields
`define PCS_IRQ_PAT_CHG 0
`define PCS_IRQ_REF_LOST 1
`define PCS_IRQ_MST_LOST 2
`define PCS_IRQ_W 3
`define PCS_IRQ_RST 3'h0

// pattern class codes
`define PCS_CODE_NONE 3'h0
`define PCS_CODE_PRBS 3'h2
`define PCS_CODE_INV 3'h3
`define PCS_CODE_ZERO 3'h6
`define PCS_CODE_ONES 3'h7

// polynomial select, order, second tap, equal-bit run length
`define PCS_POLY_11 2'h0
`define PCS_POLY_15 2'h1
`define PCS_POLY_20 2'h2
`define PCS_POLY_23 2'h3
`define PCS_ORD_11 11
`define PCS_ORD_15 15
`define PCS_ORD_20 20
`define PCS_ORD_23 23
`define PCS_TAP_11 9
`define PCS_TAP_15 14
`define PCS_TAP_20 17
`define PCS_TAP_23 18
`define PCS_RUN_11 5'd12
`define PCS_RUN_15 5'd16
`define PCS_RUN_20 5'd21
`define PCS_RUN_23 5'd24

// clock loss timing
`define PCS_CLK_MHZ 40
`define PCS_LOSS_TIME_NS 2000

`endif

// File: hw/pcs_prbs_mon.v
/*
 * serial test pattern monitor: classifies the received bit stream and
 * pulses an error flag for every bit that breaks a locked pattern.
 * assumes bits arrive with a one-cycle enable on the block clock.
 */
`default_nettype none
`include "pcs_consts.vh"

module pcs_prbs_mon #(
    parameter SYNC_RUN = 48,
    parameter LOSS_RUN = 8
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // received bit stream
    input wire bit_i,
    input wire bit_en_i,
    input wire [1:0] poly_sel_i,
    // classification
    output reg [2:0] code_o,
    output reg err_o
);
    localparam [4:0] ST_NONE = 5'h01;
    localparam [4:0] ST_PRBS = 5'h02;
    localparam [4:0] ST_INV = 5'h04;
    localparam [4:0] ST_ZERO = 5'h08;
    localparam [4:0] ST_ONES = 5'h10;
    localparam [5:0] SYNC_N = SYNC_RUN[5:0];
    localparam [5:0] LOSS_N = LOSS_RUN[5:0];

    reg [22:0] hist_q;
    reg [4:0] same_q;
    reg [5:0] mat_q;
    reg [5:0] mis_q;
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [4:0] same_d;
    reg [5:0] mat_d;
    reg [5:0] mis_d;
    reg [4:0] run_len;
    reg pred;

    // self-synchronising prediction from the bit history
    always @* begin
        case (poly_sel_i)
            `PCS_POLY_11: begin
                pred = hist_q[`PCS_ORD_11-1] ^ hist_q[`PCS_TAP_11-1];
                run_len = `PCS_RUN_11;
            end
            `PCS_POLY_15: begin
                pred = hist_q[`PCS_ORD_15-1] ^ hist_q[`PCS_TAP_15-1];
                run_len = `PCS_RUN_15;
            end
            `PCS_POLY_20: begin
                pred = hist_q[`PCS_ORD_20-1] ^ hist_q[`PCS_TAP_20-1];
                run_len = `PCS_RUN_20;
            end
            default: begin
                pred = hist_q[`PCS_ORD_23-1] ^ hist_q[`PCS_TAP_23-1];
                run_len = `PCS_RUN_23;
            end
        endcase
    end

    // run counters saturate so a long stream never wraps into a false class
    always @* begin
        same_d = (bit_i == hist_q[0]) ? ((&same_q) ? same_q : same_q + 5'd1) : 5'd1;
        mat_d = (bit_i == pred) ? ((&mat_q) ? mat_q : mat_q + 6'd1) : 6'd0;
        mis_d = (bit_i != pred) ? ((&mis_q) ? mis_q : mis_q + 6'd1) : 6'd0;
    end

    // class selection, equal-bit runs take priority over the pattern
    always @* begin
        state_d = state_q;
        if (same_d >= run_len) begin
            state_d = bit_i ? ST_ONES : ST_ZERO; // [R4]
        end else begin
            case (state_q)
                ST_PRBS: begin
                    if (mis_d >= LOSS_N) state_d = ST_NONE;
                end
                ST_INV: begin
                    if (mat_d >= LOSS_N) state_d = ST_NONE;
                end
                default: begin
                    if (mat_d >= SYNC_N) state_d = ST_PRBS;
                    else if (mis_d >= SYNC_N) state_d = ST_INV;
                    else state_d = ST_NONE;
                end
            endcase
        end
    end

    // class code of a state
    function [2:0] code_of;
        input [4:0] st;
        begin
            case (st)
                ST_PRBS: code_of = `PCS_CODE_PRBS;
                ST_INV: code_of = `PCS_CODE_INV;
                ST_ZERO: code_of = `PCS_CODE_ZERO;
                ST_ONES: code_of = `PCS_CODE_ONES;
                default: code_of = `PCS_CODE_NONE;
            endcase
        end
    endfunction

    // the error flag clears every cycle, the other registers advance only on a valid bit
    always @(posedge clk_i) begin
        if (rst_i) begin
            hist_q <= 23'h000000;
            same_q <= 5'h00;
            mat_q <= 6'h00;
            mis_q <= 6'h00;
            state_q <= ST_NONE;
            code_o <= `PCS_CODE_NONE;
            err_o <= 1'b0;
        end else begin
            err_o <= 1'b0;
            if (bit_en_i) begin
                hist_q <= {hist_q[21:0], bit_i};
                same_q <= same_d;
                mat_q <= mat_d;
                mis_q <= mis_d;
                state_q <= state_d;
                code_o <= code_of(state_d); // [R1]
                // every wrong bit of a locked pattern is one error [R5]
                err_o <= ((state_q == ST_PRBS) && (bit_i != pred)) ||
                         ((state_q == ST_INV) && (bit_i == pred));
            end
        end
    end
endmodule // pcs_prbs_mon

`default_nettype wire

// File: hw/pcs_status_top.v
/*
 * pattern and clock status block: test pattern classification, bit
 * error counter, compatibility flag, clock loss flags, interrupt logic
 * and a classic wishbone slave with 32-bit data.
 * assumes clock pins are asynchronous and the bit stream is on clk_i.
 */
// Added by the designer: the Wishbone slave port.
`default_nettype none
`include "pcs_consts.vh"

// What this block does
// R1: pattern class reported as documented 3-bit code
// R2: code change sets irq status when enabled
// R3: alarm simulation forces code to no pattern
// R4: all-zero/ones need 12/16/21/24 equal bits
// R5: every pattern bit error increments error counter; the counter saturates at all ones and then holds
// R6: compat flag bit0 is inverse of legacy disable
// R7: bits 4/3 show ref/master clock lost
// R8: reading interrupt status clears all its bits
// R9: clock and pattern status reads have no side effects
module pcs_status_top #(
    parameter SYNC_RUN = 48,
    parameter LOSS_RUN = 8,
    parameter BEC_W = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [9:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // clock pins under supervision
    input wire transmit_ref_clock_i,
    input wire transmit_master_clock_i,
    // received test bit stream
    input wire rx_bit_i,
    input wire rx_bit_en_i,
    // interrupt
    output reg irq_o
);
    // loss after this many cycles with no edge, a longest time rounds down
    localparam LOSS_CYC_I = (`PCS_LOSS_TIME_NS * `PCS_CLK_MHZ) / 1000;
    localparam LOSS_CYC = (LOSS_CYC_I < 1) ? 1 : LOSS_CYC_I;
    localparam [7:0] LOSS_N = LOSS_CYC[7:0];

    // control and status state
    reg [`PCS_CTRL_W-1:0] ctrl_q;
    reg [`PCS_IRQ_W-1:0] irq_stat_q;
    reg [`PCS_IRQ_W-1:0] irq_mask_q;
    reg [2:0] pat_code_q;
    reg [BEC_W-1:0] bec_q;
    reg [7:0] bec_hi_snap_q;

    // clock pin supervision
    reg [1:0] sync1_q;
    reg [1:0] sync2_q;
    reg [1:0] sync3_q;
    wire [1:0] lost_w;
    reg [1:0] lost_prev_q;
    wire [1:0] pin_w;

    // monitor results
    wire [2:0] mon_code;
    wire mon_err;

    // bus decode
    wire req;
    wire wr;
    wire rd;
    wire [7:0] idx;
    wire byte0;
    reg [7:0] rd_data;

    // interrupt events and clears
    reg [`PCS_IRQ_W-1:0] irq_set;
    reg [`PCS_IRQ_W-1:0] irq_clr;
    wire [2:0] pat_code_d;

    assign pin_w = {transmit_master_clock_i, transmit_ref_clock_i};

    // a request is taken in the cycle before ack rises
    assign req = cyc_i & stb_i & ~ack_o;
    assign idx = adr_i[9:2];
    assign byte0 = sel_i[0];
    assign wr = req & we_i & byte0;
    assign rd = req & ~we_i;

    // the pattern monitor itself
    pcs_prbs_mon #(
        .SYNC_RUN(SYNC_RUN),
        .LOSS_RUN(LOSS_RUN)
    ) u_mon (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bit_i(rx_bit_i),
        .bit_en_i(rx_bit_en_i),
        .poly_sel_i(ctrl_q[`PCS_CTRL_POLY_HI:`PCS_CTRL_POLY_LO]),
        .code_o(mon_code),
        .err_o(mon_err)
    );

    // alarm simulation hides any detected pattern
    assign pat_code_d = ctrl_q[`PCS_CTRL_ALARM_SIM] ? `PCS_CODE_NONE : mon_code; // [R3]

    // code register follows the monitor every cycle, never touched by reads
    always @(posedge clk_i) begin
        if (rst_i) begin
            pat_code_q <= `PCS_CODE_NONE;
        end else begin
            pat_code_q <= pat_code_d; // [R9]
        end
    end

    // three-stage pin synchroniser, stage one feeds only stage two
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            sync3_q <= 2'h0;
        end else begin
            sync1_q <= pin_w;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // one loss detector per supervised clock
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_loss
            reg [7:0] idle_q;
            reg filt_q;
            reg filt_prev_q;
            reg lost_q;
            // a level is accepted once stages two and three agree
            always @(posedge clk_i) begin
                if (rst_i) begin
                    filt_q <= 1'b0;
                    filt_prev_q <= 1'b0;
                end else begin
                    if (sync2_q[gi] == sync3_q[gi]) filt_q <= sync3_q[gi];
                    filt_prev_q <= filt_q;
                end
            end
            // per-detector flag, one driver per bit of the vector
            assign lost_w[gi] = lost_q;
            // idle counter restarts on every accepted edge
            always @(posedge clk_i) begin
                if (rst_i) begin
                    idle_q <= 8'h00;
                    lost_q <= 1'b1;
                end else if (filt_q != filt_prev_q) begin
                    idle_q <= 8'h00;
                    lost_q <= 1'b0; // [R7]
                end else if (idle_q >= LOSS_N - 8'h01) begin
                    lost_q <= 1'b1; // [R7]
                end else begin
                    idle_q <= idle_q + 8'h01;
                end
            end
        end
    endgenerate

    // previous loss flags, for interrupt edges
    always @(posedge clk_i) begin
        if (rst_i) begin
            lost_prev_q <= 2'h3;
        end else begin
            lost_prev_q <= lost_w;
        end
    end

    // interrupt events and software clears
    always @* begin
        irq_set = {`PCS_IRQ_W{1'b0}};
        irq_set[`PCS_IRQ_PAT_CHG] = (pat_code_d != pat_code_q) &
                                    ctrl_q[`PCS_CTRL_IRQ_EN]; // [R2]
        irq_set[`PCS_IRQ_REF_LOST] = lost_w[0] & ~lost_prev_q[0];
        irq_set[`PCS_IRQ_MST_LOST] = lost_w[1] & ~lost_prev_q[1];
        irq_clr = {`PCS_IRQ_W{1'b0}};
        if (rd && idx == `PCS_IDX_IRQ_STAT) begin
            irq_clr = {`PCS_IRQ_W{1'b1}}; // [R8]
        end else if (wr && idx == `PCS_IDX_IRQ_STAT) begin
            irq_clr = dat_i[`PCS_IRQ_W-1:0];
        end
    end

    // sticky status, an event in the clearing cycle survives
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= `PCS_IRQ_RST;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set; // [R2] [R8]
        end
    end

    // level interrupt, registered so the output leaves a flip-flop
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
        end
    end

    // control and mask registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `PCS_CTRL_RST;
            irq_mask_q <= `PCS_IRQ_RST;
        end else if (wr) begin
            case (idx)
                `PCS_IDX_CTRL: ctrl_q <= dat_i[`PCS_CTRL_W-1:0];
                `PCS_IDX_IRQ_MASK: irq_mask_q <= dat_i[`PCS_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // saturating error counter, a write to the low byte clears it;
    // an error in the clearing cycle is kept as the first count
    always @(posedge clk_i) begin
        if (rst_i) begin
            bec_q <= {BEC_W{1'b0}};
        end else if (wr && idx == `PCS_IDX_BEC_LO) begin
            bec_q <= {{(BEC_W-1){1'b0}}, mon_err}; // [R5]
        end else if (mon_err && !(&bec_q)) begin
            bec_q <= bec_q + {{(BEC_W-1){1'b0}}, 1'b1}; // [R5]
        end
    end

    // reading the low byte freezes the high byte for a coherent pair
    always @(posedge clk_i) begin
        if (rst_i) begin
            bec_hi_snap_q <= 8'h00;
        end else if (rd && idx == `PCS_IDX_BEC_LO) begin
            bec_hi_snap_q <= bec_q[15:8];
        end
    end

    // read multiplexer, unmapped indices read as zero
    always @* begin
        rd_data = 8'h00;
        case (idx)
            `PCS_IDX_DEV_MODE: begin
                rd_data[`PCS_BIT_COMPAT] = ~ctrl_q[`PCS_CTRL_LEGACY_DIS]; // [R6]
            end
            `PCS_IDX_CLK_STAT: begin
                rd_data[`PCS_BIT_REF_LOST] = lost_w[0]; // [R7] [R9]
                rd_data[`PCS_BIT_MST_LOST] = lost_w[1]; // [R7] [R9]
            end
            `PCS_IDX_PAT_STAT: rd_data[2:0] = pat_code_q; // [R1] [R9]
            `PCS_IDX_CTRL: rd_data[`PCS_CTRL_W-1:0] = ctrl_q;
            `PCS_IDX_IRQ_STAT: rd_data[`PCS_IRQ_W-1:0] = irq_stat_q;
            `PCS_IDX_IRQ_MASK: rd_data[`PCS_IRQ_W-1:0] = irq_mask_q;
            `PCS_IDX_BEC_LO: rd_data = bec_q[7:0];
            `PCS_IDX_BEC_HI: rd_data = bec_hi_snap_q;
            default: rd_data = 8'h00;
        endcase
    end

    // single-cycle answer: ack one cycle after the strobe, then drops
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req;
            if (rd) begin
                dat_o <= {24'h000000, rd_data};
            end else if (req) begin
                dat_o <= 32'h00000000;
            end
        end
    end
endmodule // pcs_status_top

`default_nettype wire

// File: verif/pcs_status_asserts.sv
/* checker for pcs_status_top: bus answer timing, status fields and flags.
   assumes it is bound onto the top module and everything runs on clk_i. */
`default_nettype none
`include "pcs_consts.vh"
module pcs_status_asserts (
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // pins and interrupt
    input wire logic transmit_ref_clock_i,
    input wire logic transmit_master_clock_i,
    input wire logic rx_bit_i,
    input wire logic rx_bit_en_i,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = cyc_i && stb_i && !ack_o;
    wire wr_ctl = take && we_i && sel_i[0];
    logic [7:0] idx_q;
    logic wr_q;
    logic [4:0] ctrl_q;
    logic [2:0] mask_q;
    logic [6:0] rc_q;
    logic [6:0] mc_q;
    logic rp_q;
    logic mp_q;
    wire rd_ack = ack_o && !wr_q;
    // shadow of the last request and of written control fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_q <= 8'h00;
            wr_q <= 1'b1;
            ctrl_q <= 5'h00;
            mask_q <= 3'h0;
        end else begin
            if (take) idx_q <= adr_i[9:2];
            if (take) wr_q <= we_i;
            if (wr_ctl && adr_i[9:2] == `PCS_IDX_CTRL) ctrl_q <= dat_i[4:0];
            if (wr_ctl && adr_i[9:2] == `PCS_IDX_IRQ_MASK) mask_q <= dat_i[2:0];
        end
    end
    // cycles since each pin last moved; saturated means lost, as after reset
    always_ff @(posedge clk_i) begin
        rp_q <= transmit_ref_clock_i;
        mp_q <= transmit_master_clock_i;
        if (rst_i) rc_q <= 7'h7F;
        else if (transmit_ref_clock_i != rp_q) rc_q <= 7'h00;
        else if (rc_q != 7'h7F) rc_q <= rc_q + 7'h01;
        if (rst_i) mc_q <= 7'h7F;
        else if (transmit_master_clock_i != mp_q) mc_q <= 7'h00;
        else if (mc_q != 7'h7F) mc_q <= mc_q + 7'h01;
    end
    sequence s_take;
        take;
    endsequence
    sequence s_answer;
        ack_o ##1 !ack_o;
    endsequence
    AST_ACK_ONCE: assert property (s_take |=> s_answer)
        else $error("ack not a single pulse one cycle after request");
    AST_UNMAPPED: assert property (rd_ack && !(idx_q inside {[8'hE1:8'hE7], 8'hFE}) |-> dat_o == 0)
        else $error("unmapped read not zero");
    AST_COMPAT: assert property (rd_ack && idx_q == `PCS_IDX_DEV_MODE
        |-> dat_o[0] == !ctrl_q[0]) else $error("compat flag wrong");
    AST_REF_FLAG: assert property (rd_ack && idx_q == `PCS_IDX_CLK_STAT
        && ($past(rc_q) > 99 || $past(rc_q) inside {[8:60]}) |-> dat_o[4] == ($past(rc_q) > 99))
        else $error("ref clock flag wrong");
    AST_MST_FLAG: assert property (rd_ack && idx_q == `PCS_IDX_CLK_STAT
        && ($past(mc_q) > 99 || $past(mc_q) inside {[8:60]}) |-> dat_o[3] == ($past(mc_q) > 99))
        else $error("master clock flag wrong");
    AST_CODE_LEGAL: assert property (rd_ack && idx_q == `PCS_IDX_PAT_STAT
        |-> dat_o[2:0] inside {3'h0, 3'h2, 3'h3, 3'h6, 3'h7}) else $error("reserved code");
    AST_ALARM_NONE: assert property (rd_ack && idx_q == `PCS_IDX_PAT_STAT
        && ctrl_q[2] && $past(ctrl_q[2], 3) |-> dat_o[2:0] == 3'h0) else $error("alarm code");
    AST_IRQ_MASKED: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq_o)
        else $error("irq with all masked");
endmodule // pcs_status_asserts
bind pcs_status_top pcs_status_asserts u_pcs_status_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .transmit_ref_clock_i(transmit_ref_clock_i),
    .transmit_master_clock_i(transmit_master_clock_i), .rx_bit_i(rx_bit_i),
    .rx_bit_en_i(rx_bit_en_i), .irq_o(irq_o));
`default_nettype wire

// File: verif/tb_top.sv
/* self-checking bench for pcs_status_top: wishbone master, clock pin
   toggling and test bit streams. assumes design and checker compiled first. */
`default_nettype none
`include "pcs_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic ref_i = 1'b0;
    logic mst_i = 1'b0;
    logic bit_i = 1'b0;
    logic ben_i = 1'b0;
    logic ref_run = 1'b0;
    logic mst_run = 1'b0;
    wire [31:0] dat_o;
    wire ack_o;
    wire irq_o;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [31:0] q_e[$];
    logic [31:0] q_m[$];
    logic [1:0] poly;
    logic [7:0] cw;
    logic [23:0] hist;
    int runs[4] = '{`PCS_RUN_11, `PCS_RUN_15, `PCS_RUN_20, `PCS_RUN_23};
    int ords[4] = '{`PCS_ORD_11, `PCS_ORD_15, `PCS_ORD_20, `PCS_ORD_23};
    int taps[4] = '{`PCS_TAP_11, `PCS_TAP_15, `PCS_TAP_20, `PCS_TAP_23};
    logic [7:0] ri[10] = '{8'hE0, `PCS_IDX_PAT_STAT, `PCS_IDX_CTRL, `PCS_IDX_IRQ_STAT,
        `PCS_IDX_IRQ_MASK, `PCS_IDX_BEC_LO, `PCS_IDX_BEC_HI, `PCS_IDX_DEV_MODE,
        `PCS_IDX_CLK_STAT, 8'hFF};
    logic [7:0] re[10] = '{0, 0, 0, 0, 0, 0, 0, 8'h01, 8'h18, 0};
    logic [7:0] rm[10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h18, 8'hFF};

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    pcs_status_top u_pcs_status_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .transmit_ref_clock_i(ref_i),
        .transmit_master_clock_i(mst_i), .rx_bit_i(bit_i), .rx_bit_en_i(ben_i),
        .irq_o(irq_o));

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // upper 24 bits compared on every read, they must read zero; writes compare nothing
    task automatic cmp_dat(input logic [31:0] e, input logic [31:0] m);
        n_tests++;
        if (((dat_o ^ e) & m) !== 32'h0) begin
            n_mismatch++;
            $display("Error dat_o expected %h seen %h", e & m, dat_o & m);
        end
    endtask

    task automatic cmp_irq(input logic e);
        n_tests++;
        if (irq_o !== e) begin
            n_mismatch++;
            $display("Error irq_o expected %b seen %b", e, irq_o);
        end
    endtask

    // read data monitor: every ack retires the oldest note
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && q_e.size() > 0) cmp_dat(q_e.pop_front(), q_m.pop_front());
    end

    // classic single cycle, entered right after an edge
    task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d,
                      input logic [7:0] e, input logic [7:0] m);
        int k;
        q_e.push_back({24'h0, e});
        q_m.push_back(w ? 32'h0 : {24'hFFFFFF, m});
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {ix, 2'b00};
        dat_i <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 64);
        if (k < 64) begin
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            @(posedge clk_i);
        end else begin
            n_mismatch++;
            finish_test();
        end
    endtask

    // one bit every other cycle, so the enable is never assigned twice at once
    task automatic sb(input logic b);
        bit_i <= b;
        ben_i <= 1'b1;
        @(posedge clk_i);
        ben_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic runb(input int n, input logic b);
        repeat (n) sb(b);
        repeat (3) @(posedge clk_i);
    endtask

    // generator keeps the true bits, so a flipped or inverted bit is a real error
    task automatic prbs(input int n, input logic inv, input logic flip_last);
        logic nb;
        for (int i = 0; i < n; i++) begin
            nb = hist[ords[poly] - 1] ^ hist[taps[poly] - 1];
            hist = {hist[22:0], nb};
            sb(nb ^ inv ^ (flip_last && i == n - 1));
        end
        repeat (3) @(posedge clk_i);
    endtask

    // supervised pins toggle every fourth cycle; a level must last past
    // the two-stage agreement filter, so a pin toggling each cycle is never seen
    logic [1:0] pdiv = 2'h0;
    always @(posedge clk_i) begin
        pdiv <= pdiv + 2'h1;
        if (ref_run && pdiv == 2'h3) ref_i <= ~ref_i;
        if (mst_run && pdiv == 2'h3) mst_i <= ~mst_i;
    end

    initial begin
        void'($urandom(32'hAB481B9A));
        poly = 2'($urandom);
        hist = 24'($urandom) | 24'h000001;
        cw = {3'h0, poly, 3'h0};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, read-only and unmapped places
        wb(1'b1, 8'hE0, 8'hFF, 8'h00, 8'h00);
        for (int i = 0; i < 10; i++) wb(1'b0, ri[i], 8'h00, re[i], rm[i]);
        ref_run <= 1'b1;
        mst_run <= 1'b1;
        repeat (40) @(posedge clk_i);
        wb(1'b0, `PCS_IDX_CLK_STAT, 8'h00, 8'h00, 8'h18);
        ref_run <= 1'b0;
        repeat (120) @(posedge clk_i);
        wb(1'b0, `PCS_IDX_CLK_STAT, 8'h00, 8'h10, 8'h18);
        ref_run <= 1'b1;
        repeat (40) @(posedge clk_i);
        wb(1'b0, `PCS_IDX_CLK_STAT, 8'h00, 8'h00, 8'h18);
        wb(1'b0, `PCS_IDX_IRQ_STAT, 8'h00, 8'h02, 8'h02);
        wb(1'b0, `PCS_IDX_IRQ_STAT, 8'h00, 8'h00, 8'h07);
        // legacy disable, and a write without lane 0 that must not land
        wb(1'b1, `PCS_IDX_CTRL, cw | 8'h01, 8'h00, 8'h00);
        wb(1'b0, `PCS_IDX_DEV_MODE, 8'h00, 8'h00, 8'h01);
        sel_i <= 4'hE;
        wb(1'b1, `PCS_IDX_CTRL, cw, 8'h00, 8'h00);
        sel_i <= 4'hF;
        wb(1'b0, `PCS_IDX_CTRL, 8'h00, cw | 8'h01, 8'h1F);
        wb(1'b1, `PCS_IDX_CTRL, cw, 8'h00, 8'h00);
        wb(1'b0, `PCS_IDX_DEV_MODE, 8'h00, 8'h01, 8'h01);
        // equal-bit run one short, then complete, change enable off
        runb(runs[poly] - 1, 1'b1);
        wb(1'b0, `PCS_IDX_PAT_STAT, 8'h00, 8'h00, 8'h07);
        runb(1, 1'b1);
        wb(1'b0, `PCS_IDX_PAT_STAT, 8'h00, 8'h07, 8'h07);
        wb(1'b0, `PCS_IDX_PAT_STAT, 8'h00, 8'h07, 8'h07);
        wb(1'b0, `PCS_IDX_IRQ_STAT, 8'h00, 8'h00, 8'h01);
        wb(1'b1, `PCS_IDX_IRQ_MASK, 8'h01, 8'h00, 8'h00);
        wb(1'b1, `PCS_IDX_CTRL, cw | 8'h02, 8'h00, 8'h00);
        runb(runs[poly], 1'b0);
        wb(1'b0, `PCS_IDX_PAT_STAT, 8'h00, 8'h06, 8'h07);
        cmp_irq(1'b1);
        wb(1'b0, `PCS_IDX_IRQ_STAT, 8'h00, 8'h01, 8'h01);
        cmp_irq(1'b0);
        // alarm simulation forces no pattern and counts as a change
        wb(1'b1, `PCS_IDX_CTRL, cw | 8'h06, 8'h00, 8'h00);
        wb(1'b0, `PCS_IDX_PAT_STAT, 8'h00, 8'h00, 8'h07);
        wb(1'b0, `PCS_IDX_IRQ_STAT, 8'h00, 8'h01, 8'h01);
        wb(1'b1, `PCS_IDX_CTRL, cw | 8'h02, 8'h00, 8'h00);
        // locked pattern, one error as the very last bit, then inverted
        prbs(100, 1'b0, 1'b0);
        wb(1'b0, `PCS_IDX_PAT_STAT, 8'h00, 8'h02, 8'h07);
        wb(1'b1, `PCS_IDX_BEC_LO, 8'h00, 8'h00, 8'h00);
        prbs(40, 1'b0, 1'b1);
        wb(1'b0, `PCS_IDX_BEC_LO, 8'h00, 8'h01, 8'hFF);
        wb(1'b0, `PCS_IDX_BEC_HI, 8'h00, 8'h00, 8'hFF);
        prbs(150, 1'b1, 1'b0);
        wb(1'b0, `PCS_IDX_PAT_STAT, 8'h00, 8'h03, 8'h07);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
